// [design/usbsw_ctrl.sv]
// USB supply switch control with AXI4-Lite register slave
//
// Behaviour
// - Source-select 0 closes bus-to-regulator switch, opens boost-to-regulator switch; with OTG 1 all switches open.
// - OTG 0, select 0: only bus-to-regulator switch closed.
// - OTG 0, select 1: only boost-to-regulator switch closed.
// - OTG 1, select 1: boost-to-regulator and boost-to-bus closed, bus switch open.
// - Boost-to-bus switch stays open whenever OTG mode is not selected.
// - Switch bits never start the boost; software sets boost enable separately.
// - Straps 0100: regulator on by default, fed from boost supply.
// - Other straps: regulator runs only while bus voltage is valid.
// - Other straps, bus present at cold start: regulator enabled, fed from VBUS.
// - Other straps: bus appearing later turns the regulator on automatically, fed from VBUS.
// - Other straps: enable bit reloads to 1 on system reset or bus loss.
// - Straps 0100: enable bit is set as a power-up sequence step.
// - In OTG mode regulator turns on only after software writes enable 1; with other straps the code still reloads enable on system reset or bus loss.
// - Boost driving VBUS in OTG mode raises the bus-detect event.
// - Accessory configured raises interrupt; host reads cause over registers.
// - ID line digitised by 5-bit converter, 32 levels, also remote buttons.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module usbsw_ctrl
  import usbsw_pkg::*;
#(
  parameter int SETTLE_CYC = USBSW_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Pins from outside the clock domain
  input  wire logic                      vbus_valid,
  input  wire logic [3:0]                powerup_mode_straps,
  input  wire logic                      system_reset_n,
  // Accessory logic and ID converter, same clock
  input  wire logic                      accessory_configured,
  input  wire logic                      id_adc_done,
  input  wire logic [USBSW_ID_ADC_W-1:0] id_adc_value,
  // Supply path outputs
  output logic                           bus_to_ldo_switch,
  output logic                           boost_to_ldo_switch,
  output logic                           boost_to_bus_switch,
  output logic                           phy_ldo_on,
  output logic                           boost_enable,
  // Interrupt to host, active low
  output logic                           irq_n
);
  // Strap code test, used by strap capture and the strap-step control load
  function automatic logic strap_is_boost(input logic [3:0] s);
    strap_is_boost = (s == USBSW_STRAP_BOOST);
  endfunction : strap_is_boost

  logic                      vbus_s;
  logic [3:0]                straps_s;
  logic                      sysrst_n_s;
  logic                      vbus_d_r;
  usbsw_state_t              state_r;
  logic [7:0]                settle_r;
  logic [3:0]                straps_r;
  logic                      boost_strap_r;
  logic [3:0]                ctrl_r;
  logic [USBSW_EVT_W-1:0]    evt_r;
  logic [USBSW_EVT_W-1:0]    evt_nxt;
  logic [USBSW_ID_ADC_W-1:0] id_adc_r;
  logic                      otg_drive_d_r;
  logic                      dec_bus;
  logic                      dec_bst;
  logic                      dec_otg;
  logic                      aw_held_r;
  logic [3:0]                aw_addr_r;
  logic                      w_held_r;
  logic [31:0]               w_data_r;
  logic [3:0]                w_strb_r;
  logic                      wr_go;
  logic                      wr_ctrl;
  logic                      wr_evt;
  logic [7:0]                ctrl_wbyte;
  logic                      ldo_reload;
  logic                      otg_drive_now;
  logic [31:0]               rd_word;
  logic                      rd_hit;

  // Pin synchronisers
  usbsw_sync #(.W(1), .RST(1'b0)) u_sync_vbus (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (vbus_valid),
    .sync_out (vbus_s)
  );
  usbsw_sync #(.W(4), .RST(4'h0)) u_sync_strap (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (powerup_mode_straps),
    .sync_out (straps_s)
  );
  usbsw_sync #(.W(1), .RST(1'b1)) u_sync_sysrst (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (system_reset_n),
    .sync_out (sysrst_n_s)
  );

  // Switch decoder on the software mode bits
  usbsw_switch_dec u_dec (
    .ldo_source_select   (ctrl_r[USBSW_CTRL_SRC_BIT]),
    .otg_drive_enable    (ctrl_r[USBSW_CTRL_OTG_BIT]),
    .bus_to_ldo_switch   (dec_bus),
    .boost_to_ldo_switch (dec_bst),
    .boost_to_bus_switch (dec_otg)
  );

  // Startup sequencer; straps are only trusted once the synchroniser has settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= USBSW_ST_SETTLE;
      settle_r <= 8'h00;
    end else begin
      case (state_r)
        USBSW_ST_SETTLE: begin
          settle_r <= settle_r + 8'h01;
          if (settle_r >= 8'(SETTLE_CYC - 1)) begin
            state_r <= USBSW_ST_STRAP;
          end
        end
        USBSW_ST_STRAP: begin
          state_r <= USBSW_ST_RUN;
        end
        USBSW_ST_RUN: begin
          state_r <= USBSW_ST_RUN;
        end
        default: begin
          state_r <= USBSW_ST_SETTLE;
        end
      endcase
    end
  end

  // Strap capture after reset release, never in the reset branch itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_r      <= 4'h0;
      boost_strap_r <= 1'b0;
    end else if (state_r == USBSW_ST_STRAP) begin
      straps_r      <= straps_s;
      boost_strap_r <= strap_is_boost(straps_s);
    end
  end

  // Write channel: address and data are taken in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; status register is read-only and answers OKAY on write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= USBSW_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_r[3:2] <= USBSW_OFS_IDADC[3:2]) ? USBSW_RESP_OKAY : USBSW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // All writable fields sit in byte lane 0
  assign ctrl_wbyte = w_data_r[7:0];
  assign wr_ctrl    = wr_go && w_strb_r[0] && (aw_addr_r[3:2] == USBSW_OFS_CTRL[3:2]);
  assign wr_evt     = wr_go && w_strb_r[0] && (aw_addr_r[3:2] == USBSW_OFS_EVENT[3:2]);

  // Enable reload: with straps other than 0100, system reset or bus loss undoes a software disable
  assign ldo_reload = !boost_strap_r && (state_r == USBSW_ST_RUN) &&
                      (!sysrst_n_s || (vbus_d_r && !vbus_s));

  // Control bits; hardware reload of the enable wins over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= USBSW_CTRL_RST;
    end else if (state_r == USBSW_ST_STRAP) begin
      ctrl_r[USBSW_CTRL_LDO_BIT] <= 1'b1;
      ctrl_r[USBSW_CTRL_SRC_BIT] <= strap_is_boost(straps_s);
      ctrl_r[USBSW_CTRL_OTG_BIT] <= 1'b0;
      ctrl_r[USBSW_CTRL_BST_BIT] <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_wbyte[3:0];
      end
      if (ldo_reload) begin
        ctrl_r[USBSW_CTRL_LDO_BIT] <= 1'b1;
      end
    end
  end

  // Edge trackers for bus voltage and OTG drive
  assign otg_drive_now = dec_otg && ctrl_r[USBSW_CTRL_BST_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbus_d_r      <= 1'b0;
      otg_drive_d_r <= 1'b0;
    end else begin
      vbus_d_r      <= vbus_s;
      otg_drive_d_r <= otg_drive_now;
    end
  end

  // Sticky events: set wins over a write-one clear in the same cycle
  always_comb begin
    evt_nxt = evt_r;
    if (wr_evt) begin
      evt_nxt = evt_r & ~ctrl_wbyte[USBSW_EVT_W-1:0];
    end
    if (vbus_d_r != vbus_s) begin
      evt_nxt[USBSW_EVT_BUSDET_BIT] = 1'b1;
    end
    if (otg_drive_now && !otg_drive_d_r) begin
      evt_nxt[USBSW_EVT_BUSDET_BIT] = 1'b1;
    end
    if (accessory_configured) begin
      evt_nxt[USBSW_EVT_ACC_BIT] = 1'b1;
    end
    if (id_adc_done) begin
      evt_nxt[USBSW_EVT_ADC_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_r <= USBSW_EVT_RST;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // ID converter result, held until the next conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      id_adc_r <= '0;
    end else if (id_adc_done) begin
      id_adc_r <= id_adc_value;
    end
  end

  // Registered supply outputs; boost enable is independent of the switches
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != USBSW_ST_RUN) begin
      bus_to_ldo_switch   <= 1'b0;
      boost_to_ldo_switch <= 1'b0;
      boost_to_bus_switch <= 1'b0;
      phy_ldo_on          <= 1'b0;
      boost_enable        <= 1'b0;
    end else begin
      bus_to_ldo_switch   <= dec_bus;
      boost_to_ldo_switch <= dec_bst;
      boost_to_bus_switch <= dec_otg;
      boost_enable        <= ctrl_r[USBSW_CTRL_BST_BIT];
      phy_ldo_on          <= ctrl_r[USBSW_CTRL_LDO_BIT] &&
                             (boost_strap_r || vbus_s);
    end
  end

  // Interrupt pin low while any event is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(|evt_r);
    end
  end

  // Read word mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr[3:2])
      USBSW_OFS_CTRL[3:2]: begin
        rd_word[3:0] = ctrl_r;
      end
      USBSW_OFS_STATUS[3:2]: begin
        rd_word[USBSW_ST_M_BUS_BIT] = bus_to_ldo_switch;
        rd_word[USBSW_ST_M_BST_BIT] = boost_to_ldo_switch;
        rd_word[USBSW_ST_M_OTG_BIT] = boost_to_bus_switch;
        rd_word[USBSW_ST_LDO_BIT]   = phy_ldo_on;
        rd_word[USBSW_ST_VBUS_BIT]  = vbus_s;
        rd_word[USBSW_ST_READY_BIT] = (state_r == USBSW_ST_RUN);
        rd_word[USBSW_ST_STRAP_LSB +: 4] = straps_r;
      end
      USBSW_OFS_EVENT[3:2]: begin
        rd_word[USBSW_EVT_W-1:0] = evt_r;
      end
      USBSW_OFS_IDADC[3:2]: begin
        rd_word[USBSW_ID_ADC_W-1:0] = id_adc_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one outstanding read, answered the cycle after acceptance
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= USBSW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? USBSW_RESP_OKAY : USBSW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : usbsw_ctrl

// [design/usbsw_pkg.sv]
// Shared constants and types for the USB supply switch control block
package usbsw_pkg;
  // Register byte offsets
  localparam logic [3:0] USBSW_OFS_CTRL   = 4'h0;
  localparam logic [3:0] USBSW_OFS_STATUS = 4'h4;
  localparam logic [3:0] USBSW_OFS_EVENT  = 4'h8;
  localparam logic [3:0] USBSW_OFS_IDADC  = 4'hc;
  // Control register fields
  localparam int USBSW_CTRL_SRC_BIT = 0;
  localparam int USBSW_CTRL_OTG_BIT = 1;
  localparam int USBSW_CTRL_LDO_BIT = 2;
  localparam int USBSW_CTRL_BST_BIT = 3;
  // Status register fields
  localparam int USBSW_ST_M_BUS_BIT  = 0;
  localparam int USBSW_ST_M_BST_BIT  = 1;
  localparam int USBSW_ST_M_OTG_BIT  = 2;
  localparam int USBSW_ST_LDO_BIT    = 3;
  localparam int USBSW_ST_VBUS_BIT   = 4;
  localparam int USBSW_ST_READY_BIT  = 5;
  localparam int USBSW_ST_STRAP_LSB  = 8;
  // Event register fields
  localparam int USBSW_EVT_BUSDET_BIT = 0;
  localparam int USBSW_EVT_ACC_BIT    = 1;
  localparam int USBSW_EVT_ADC_BIT    = 2;
  localparam int USBSW_EVT_W          = 3;
  // Reset values
  localparam logic [3:0] USBSW_CTRL_RST = 4'h0;
  localparam logic [2:0] USBSW_EVT_RST  = 3'h0;
  // Strap code that selects boost-fed regulator default
  localparam logic [3:0] USBSW_STRAP_BOOST = 4'h4;
  // ID converter width, resolves 32 levels
  localparam int USBSW_ID_ADC_W = 5;
  // AXI responses
  localparam logic [1:0] USBSW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] USBSW_RESP_SLVERR = 2'h2;
  // Timing: strap settle time after reset release
  localparam int USBSW_CLK_PERIOD_NS = 100;
  localparam int USBSW_SETTLE_NS     = 500;
  localparam int USBSW_SETTLE_CYC    = (USBSW_SETTLE_NS + USBSW_CLK_PERIOD_NS - 1) / USBSW_CLK_PERIOD_NS;
  // Startup sequencer states
  typedef enum logic [1:0] {
    USBSW_ST_SETTLE,
    USBSW_ST_STRAP,
    USBSW_ST_RUN
  } usbsw_state_t;
endpackage : usbsw_pkg

// [design/usbsw_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module usbsw_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pin side
  input  wire logic [W-1:0] pin_in,
  // Clean side
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out <= RST;
    end else if (s2_r == s3_r) begin
      sync_out <= s3_r;
    end
  end
endmodule : usbsw_sync

// [design/usbsw_switch_dec.sv]
// Decoder from source-select and OTG-drive bits to supply switch states
`timescale 1ns/100ps
module usbsw_switch_dec (
  // Mode bits
  input  wire logic ldo_source_select,
  input  wire logic otg_drive_enable,
  // Switch commands, high means closed
  output logic      bus_to_ldo_switch,
  output logic      boost_to_ldo_switch,
  output logic      boost_to_bus_switch
);
  // Table of the four combinations; the invalid one opens everything
  always_comb begin
    bus_to_ldo_switch   = 1'b0;
    boost_to_ldo_switch = 1'b0;
    boost_to_bus_switch = 1'b0;
    case ({otg_drive_enable, ldo_source_select})
      2'b00: begin
        bus_to_ldo_switch = 1'b1;
      end
      2'b01: begin
        boost_to_ldo_switch = 1'b1;
      end
      2'b11: begin
        boost_to_ldo_switch = 1'b1;
        boost_to_bus_switch = 1'b1;
      end
      default: begin
        bus_to_ldo_switch = 1'b0;
      end
    endcase
  end
endmodule : usbsw_switch_dec

// [sim/usbsw_ctrl_monitor.sv]
// Port checker for the USB supply switch control block
`timescale 1ns/100ps
module usbsw_ctrl_monitor
  import usbsw_pkg::*;
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus handshakes
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rready,
  // Pins
  input wire logic       vbus_valid,
  input wire logic [3:0] powerup_mode_straps,
  // Supply path and interrupt
  input wire logic       bus_to_ldo_switch,
  input wire logic       boost_to_ldo_switch,
  input wire logic       boost_to_bus_switch,
  input wire logic       phy_ldo_on,
  input wire logic       boost_enable,
  input wire logic       irq_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Switch pairs that the mode table forbids
  AST_BUS_ONLY:
    assert property (bus_to_ldo_switch |-> !boost_to_ldo_switch && !boost_to_bus_switch)
    else $error("bus switch closed together with a boost switch");
  AST_OTG_PAIR:
    assert property (boost_to_bus_switch |-> boost_to_ldo_switch && !bus_to_ldo_switch)
    else $error("boost to bus closed outside full otg mode");
  // Eight cycles cover the pin synchroniser delay
  AST_LDO_NEEDS_BUS:
    assert property ((powerup_mode_straps != USBSW_STRAP_BOOST && !vbus_valid) [*8] |-> !phy_ldo_on)
    else $error("regulator on without bus voltage");
  AST_BUSDET_IRQ:
    assert property ($rose(boost_to_bus_switch && boost_enable) |-> ##[0:3] !irq_n)
    else $error("boost driving bus raised no interrupt");
  // Boost only ever follows a register write
  AST_BOOST_SW_ONLY:
    assert property ($rose(boost_enable) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("boost enabled without a write");
  AST_BRESP_OKAY:
    assert property (s_axi_bvalid |-> s_axi_bresp == USBSW_RESP_OKAY)
    else $error("write response not okay");
  AST_B_DROP:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  AST_AR_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_R_DROP:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  // Every word of the map exists, so a read cause is always answered cleanly
  AST_RRESP_OKAY:
    assert property (s_axi_rvalid |-> s_axi_rresp == USBSW_RESP_OKAY)
    else $error("read response not okay");
endmodule : usbsw_ctrl_monitor

bind usbsw_ctrl usbsw_ctrl_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .s_axi_rready(s_axi_rready), .vbus_valid(vbus_valid),
  .powerup_mode_straps(powerup_mode_straps), .bus_to_ldo_switch(bus_to_ldo_switch),
  .boost_to_ldo_switch(boost_to_ldo_switch), .boost_to_bus_switch(boost_to_bus_switch),
  .phy_ldo_on(phy_ldo_on), .boost_enable(boost_enable), .irq_n(irq_n)
);

// [sim/usbsw_host.sv]
// Host processor model: register master that reads event causes
`timescale 1ns/100ps
module usbsw_host (
  // Clock
  input wire logic        aclk,
  // Write channels
  output logic [3:0]      awaddr,
  output logic            awvalid,
  input wire logic        awready,
  output logic [31:0]     wdata,
  output logic [3:0]      wstrb,
  output logic            wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  output logic            bready,
  // Read channels
  output logic [3:0]      araddr,
  output logic            arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  output logic            rready
);
  // Response readies stay high, so back-to-back calls never drive them twice
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, arvalid} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
  end

  // One write; each channel released when taken, payload inverted on release
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask : wr

  // One read; address released and inverted once taken, data sampled when rvalid is seen
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
  endtask : rd
endmodule : usbsw_host

// [sim/usbsw_ctrl_tb_top.sv]
// Self-checking bench for the USB supply switch control block
`timescale 1ns/100ps
module usbsw_ctrl_tb_top;
  import usbsw_pkg::*;
  logic        aclk, aresetn, vbus_valid, system_reset_n, accessory_configured, id_adc_done;
  logic [3:0]  powerup_mode_straps;
  logic [4:0]  id_adc_value;
  logic [7:0]  seed;
  logic [3:0]  straps_v;
  logic [31:0] rd_val;
  wire  [3:0]  awaddr, araddr, wstrb;
  wire  [31:0] wdata, rdata;
  wire         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  wire         b2l, x2l, x2b, ldo_on, bst_en, irq_n;
  int          n_errors;
  int          checks_done;

  usbsw_ctrl dut (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vbus_valid, .powerup_mode_straps,
    .system_reset_n, .accessory_configured, .id_adc_done, .id_adc_value,
    .bus_to_ldo_switch(b2l), .boost_to_ldo_switch(x2l), .boost_to_bus_switch(x2b),
    .phy_ldo_on(ldo_on), .boost_enable(bst_en), .irq_n
  );
  usbsw_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready);

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Expected {boost_to_bus, boost_to_ldo, bus_to_ldo} for {otg, source}
  function automatic logic [2:0] exp_sw(input logic [1:0] m);
    case (m)
      2'b00: return 3'b001;
      2'b01: return 3'b010;
      2'b11: return 3'b110;
      default: return 3'b000;
    endcase
  endfunction : exp_sw

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // Cold start; the wait covers settle, strap step and synchronisers
  task automatic start(input logic [3:0] straps, input logic vb);
    aresetn <= 1'b0;
    powerup_mode_straps <= straps;
    vbus_valid <= vb;
    cyc(2);
    aresetn <= 1'b1;
    cyc(12);
  endtask : start

  // Whole run needs under two hundred cycles
  initial begin
    cyc(3000);
    n_errors++;
    close_out();
  end

  initial begin
    {aresetn, accessory_configured, id_adc_done} = '0;
    {vbus_valid, system_reset_n} = 2'b11;
    powerup_mode_straps = 4'h0;
    id_adc_value = 5'h00;
    seed = 8'h5e;
    n_errors = 0;
    checks_done = 0;
    seed = lfsr(seed);
    straps_v = (seed[3:0] == 4'h4) ? 4'h5 : seed[3:0];
    start(straps_v, 1'b1);
    chk({x2b, x2l, b2l, ldo_on}, 4'b0011);
    // Status: bus switch, regulator, bus valid, ready, captured straps
    host.rd(USBSW_OFS_STATUS, rd_val);
    chk(rd_val, {20'h0, straps_v, 8'h39});
    host.rd(USBSW_OFS_CTRL, rd_val);
    chk(rd_val, 32'h4);
    // Every mode code twice, boost bit random
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      host.wr(USBSW_OFS_CTRL, {28'h0, seed[0], 1'b1, m[1:0]});
      cyc(2);
      chk({bst_en, x2b, x2l, b2l}, {seed[0], exp_sw(m[1:0])});
    end
    // Boost starts driving the bus only when its own bit is set
    host.wr(USBSW_OFS_CTRL, 32'h7);
    host.wr(USBSW_OFS_EVENT, 32'h7);
    cyc(2);
    chk(irq_n, 1'b1);
    host.wr(USBSW_OFS_CTRL, 32'hf);
    cyc(4);
    chk(irq_n, 1'b0);
    host.rd(USBSW_OFS_EVENT, rd_val);
    chk(rd_val, 32'h1);
    // Accessory and converter events
    host.wr(USBSW_OFS_EVENT, 32'h7);
    seed = lfsr(seed);
    {accessory_configured, id_adc_done, id_adc_value} <= {2'b11, seed[4:0]};
    cyc(1);
    {accessory_configured, id_adc_done} <= 2'b00;
    cyc(2);
    chk(irq_n, 1'b0);
    host.rd(USBSW_OFS_EVENT, rd_val);
    chk(rd_val, 32'h6);
    host.rd(USBSW_OFS_IDADC, rd_val);
    chk(rd_val, {27'h0, seed[4:0]});
    host.wr(USBSW_OFS_EVENT, 32'h6);
    cyc(2);
    chk(irq_n, 1'b1);
    // Software disable undone by system reset, then by bus loss
    host.wr(USBSW_OFS_CTRL, 32'h0);
    cyc(2);
    chk(ldo_on, 1'b0);
    system_reset_n <= 1'b0;
    cyc(6);
    system_reset_n <= 1'b1;
    cyc(6);
    chk({ldo_on, b2l}, 2'b11);
    host.wr(USBSW_OFS_CTRL, 32'h0);
    vbus_valid <= 1'b0;
    cyc(8);
    host.rd(USBSW_OFS_CTRL, rd_val);
    chk(rd_val, 32'h4);
    chk(ldo_on, 1'b0);
    vbus_valid <= 1'b1;
    cyc(8);
    chk(ldo_on, 1'b1);
    // Mid-run reset into boost-fed default without bus voltage
    start(USBSW_STRAP_BOOST, 1'b0);
    chk({x2b, x2l, b2l, ldo_on}, 4'b0101);
    host.rd(USBSW_OFS_CTRL, rd_val);
    chk(rd_val, 32'h5);
    host.wr(USBSW_OFS_CTRL, 32'h3);
    cyc(2);
    chk({x2b, ldo_on}, 2'b10);
    host.wr(USBSW_OFS_CTRL, 32'h7);
    cyc(2);
    chk(ldo_on, 1'b1);
    close_out();
  end
endmodule : usbsw_ctrl_tb_top
